// *** src/ssp_cfg.svh ***
// Register offsets, field positions, reset values and timing for the port.
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH
`define SSP_OFF_GLOBAL_IRQ_CTRL 8'h0B
`define SSP_OFF_PERIPH_FLAGS 8'h0C
`define SSP_OFF_SERIAL_BUFFER 8'h13
`define SSP_OFF_PORT_CONTROL 8'h14
`define SSP_OFF_PORT_C_DIR 8'h87
`define SSP_OFF_PERIPH_ENABLES 8'h8C
`define SSP_OFF_SLAVE_ADDRESS 8'h93
`define SSP_OFF_PORT_STATUS 8'h94
`define SSP_RST_REG 8'h00
`define SSP_RST_PORT_C_DIR 8'hFF
`define SSP_GIE_BIT 7
`define SSP_PERIPHERAL_IRQ_ENABLE_BIT 6
`define SSP_FLAG_BIT 3
`define SSP_CTL_WRITE_COLLISION_BIT_BIT 7
`define SSP_CTL_OV_BIT 6
`define SSP_CTL_EN_BIT 5
`define SSP_CTL_CKP_BIT 4
`define SSP_STA_STOP_BIT 4
`define SSP_STA_START_BIT 3
`define SSP_STA_RW_BIT 2
`define SSP_STA_BF_BIT 0
`define SSP_DIR_SDA_BIT 4
`define SSP_DIR_SCL_BIT 3
`define SSP_MODE_SLAVE7 4'h6
`define SSP_MODE_SLAVE_IDLE 4'hB
`define SSP_BITS_PER_BYTE 4'h8
`define SSP_LAST_TX_SHIFT 4'h7
`define SSP_HOST_QTR_CYC 8
`endif

// *** src/ssp_pkg.sv ***
// State types for each end of the two-wire port and the master command codes.
`default_nettype none
package ssp_pkg;
    typedef enum logic [2:0] {
        SSP_ST_IDLE, SSP_ST_RX, SSP_ST_RACK, SSP_ST_HOLD, SSP_ST_TX,
        SSP_ST_TACK
    } ssp_dev_state_t;
    typedef enum logic [1:0] {
        SSP_H_IDLE, SSP_H_START, SSP_H_BIT, SSP_H_STOP
    } ssp_host_state_t;
    typedef enum logic [1:0] {
        SSP_CMD_START, SSP_CMD_WRITE, SSP_CMD_READ, SSP_CMD_STOP
    } ssp_cmd_t;
endpackage
`default_nettype wire

// *** src/ssp_if.sv ***
// Open-drain two-wire bus joining the port and the bus master.
`default_nettype none
interface ssp_if;
    logic dev_scl_oe;
    logic dev_sda_oe;
    logic host_scl_oe;
    logic host_sda_oe;
    logic scl;
    logic sda;
    assign scl = ~(dev_scl_oe | host_scl_oe);
    assign sda = ~(dev_sda_oe | host_sda_oe);
    modport dev (output dev_scl_oe, output dev_sda_oe, input scl, input sda);
    modport host (output host_scl_oe, output host_sda_oe, input scl,
        input sda);
endinterface
`default_nettype wire

// *** src/ssp_dev.sv ***
// Serial port device end: slave transmit, bus monitor and registers.
`default_nettype none
`include "ssp_cfg.svh"
module ssp_dev import ssp_pkg::*; (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic irq,
    ssp_if.dev bus
);
    // ------------------------------------------------------------
    // Registers and synchronisers.
    // ------------------------------------------------------------
    logic [7:0] ictl_q, pie_q, buf_q, ctl_q, dir_q, adr_q, sr_q, rdata_q;
    logic flag_q, stop_q, start_q, rw_q, bf_q, sda_low_q, addr_ph_q, ack_q;
    logic [3:0] cnt_q;
    ssp_dev_state_t st_q;
    logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;

    always_ff @(posedge sys_clk) begin
        scl_m_q <= bus.scl;
        scl_s_q <= scl_m_q;
        scl_p_q <= scl_s_q;
        sda_m_q <= bus.sda;
        sda_s_q <= sda_m_q;
        sda_p_q <= sda_s_q;
    end

    // ------------------------------------------------------------
    // Decoding and bus events.
    // ------------------------------------------------------------
    wire scl_rise = scl_s_q & ~scl_p_q;
    wire scl_fall = ~scl_s_q & scl_p_q;
    wire start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    wire stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
    wire en = ctl_q[`SSP_CTL_EN_BIT];
    wire clock_release_bit = ctl_q[`SSP_CTL_CKP_BIT];
    wire slave_on = en & (ctl_q[3:0] == `SSP_MODE_SLAVE7);
    wire addr_match = sr_q[7:1] == adr_q[7:1];
    wire busy_tx = (st_q == SSP_ST_TX) || (st_q == SSP_ST_TACK);
    wire wr_ictl = reg_wr && reg_addr == `SSP_OFF_GLOBAL_IRQ_CTRL;
    wire wr_pir = reg_wr && reg_addr == `SSP_OFF_PERIPH_FLAGS;
    wire wr_buf = reg_wr && reg_addr == `SSP_OFF_SERIAL_BUFFER;
    wire wr_ctl = reg_wr && reg_addr == `SSP_OFF_PORT_CONTROL;
    wire wr_dir = reg_wr && reg_addr == `SSP_OFF_PORT_C_DIR;
    wire wr_pie = reg_wr && reg_addr == `SSP_OFF_PERIPH_ENABLES;
    wire wr_adr = reg_wr && reg_addr == `SSP_OFF_SLAVE_ADDRESS;
    wire rd_buf = reg_rd && reg_addr == `SSP_OFF_SERIAL_BUFFER;
    wire flag_clr = wr_pir & reg_wdata[`SSP_FLAG_BIT];
    wire [7:0] pir_val = {4'h0, flag_q, 3'h0};
    wire [7:0] sta_val = {3'h0, stop_q, start_q, rw_q, 1'b0, bf_q};
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr)
            `SSP_OFF_GLOBAL_IRQ_CTRL: rd_mux = ictl_q;
            `SSP_OFF_PERIPH_FLAGS: rd_mux = pir_val;
            `SSP_OFF_SERIAL_BUFFER: rd_mux = buf_q;
            `SSP_OFF_PORT_CONTROL: rd_mux = ctl_q;
            `SSP_OFF_PORT_C_DIR: rd_mux = dir_q;
            `SSP_OFF_PERIPH_ENABLES: rd_mux = pie_q;
            `SSP_OFF_SLAVE_ADDRESS: rd_mux = adr_q;
            `SSP_OFF_PORT_STATUS: rd_mux = sta_val;
            default: rd_mux = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // Pins and interrupt.
    // ------------------------------------------------------------
    wire scl_hold = st_q == SSP_ST_HOLD;
    assign bus.dev_sda_oe = ~dir_q[`SSP_DIR_SDA_BIT] | sda_low_q;
    assign bus.dev_scl_oe = ~dir_q[`SSP_DIR_SCL_BIT] | scl_hold;
    assign irq = ictl_q[`SSP_GIE_BIT] & ictl_q[`SSP_PERIPHERAL_IRQ_ENABLE_BIT] & flag_q
        & pie_q[`SSP_FLAG_BIT];
    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // Software access and slave state machine.
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ictl_q <= `SSP_RST_REG;
            pie_q <= `SSP_RST_REG;
            buf_q <= `SSP_RST_REG;
            ctl_q <= `SSP_RST_REG;
            dir_q <= `SSP_RST_PORT_C_DIR;
            adr_q <= `SSP_RST_REG;
            sr_q <= `SSP_RST_REG;
            rdata_q <= 8'h00;
            flag_q <= 1'b0;
            stop_q <= 1'b0;
            start_q <= 1'b0;
            rw_q <= 1'b0;
            bf_q <= 1'b0;
            sda_low_q <= 1'b0;
            addr_ph_q <= 1'b0;
            ack_q <= 1'b0;
            cnt_q <= 4'h0;
            st_q <= SSP_ST_IDLE;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 8'h00;
            if (wr_ictl) begin
                ictl_q <= reg_wdata;
            end
            if (wr_pie) begin
                pie_q <= reg_wdata;
            end
            if (wr_adr) begin
                adr_q <= reg_wdata;
            end
            if (wr_dir) begin
                dir_q <= reg_wdata;
            end
            if (wr_ctl) begin
                ctl_q <= reg_wdata;
            end
            if (flag_clr) begin
                flag_q <= 1'b0;
            end
            if (rd_buf) begin
                bf_q <= 1'b0;
            end
            if (wr_buf) begin
                if (busy_tx) begin
                    ctl_q[`SSP_CTL_WRITE_COLLISION_BIT_BIT] <= 1'b1;
                end else begin
                    buf_q <= reg_wdata;
                    bf_q <= 1'b1;
                    if (st_q != SSP_ST_RX) begin
                        sr_q <= reg_wdata;
                    end
                end
            end
            case (st_q)
                SSP_ST_IDLE: begin
                end
                SSP_ST_RX: begin
                    if (scl_rise) begin
                        sr_q <= {sr_q[6:0], sda_s_q};
                        cnt_q <= cnt_q + 4'h1;
                    end
                    if (scl_fall && cnt_q == `SSP_BITS_PER_BYTE) begin
                        cnt_q <= 4'h0;
                        st_q <= SSP_ST_RACK;
                        if (addr_ph_q) begin
                            sda_low_q <= addr_match;
                            if (!addr_match) begin
                                st_q <= SSP_ST_IDLE;
                            end
                        end else if (bf_q || ctl_q[`SSP_CTL_OV_BIT]) begin
                            ctl_q[`SSP_CTL_OV_BIT] <= 1'b1;
                        end else begin
                            buf_q <= sr_q;
                            bf_q <= 1'b1;
                            sda_low_q <= 1'b1;
                        end
                    end
                end
                SSP_ST_RACK: begin
                    if (scl_fall) begin
                        sda_low_q <= 1'b0;
                        flag_q <= 1'b1;
                        addr_ph_q <= 1'b0;
                        st_q <= SSP_ST_RX;
                        if (addr_ph_q) begin
                            rw_q <= sr_q[0];
                        end
                        if (addr_ph_q && sr_q[0]) begin
                            buf_q <= sr_q;
                            ctl_q[`SSP_CTL_CKP_BIT] <= 1'b0;
                            st_q <= SSP_ST_HOLD;
                        end
                    end
                end
                SSP_ST_HOLD: begin
                    if (clock_release_bit) begin
                        sda_low_q <= ~sr_q[7];
                        bf_q <= 1'b0;
                        cnt_q <= 4'h0;
                        st_q <= SSP_ST_TX;
                    end
                end
                SSP_ST_TX: begin
                    if (scl_fall) begin
                        if (cnt_q == `SSP_LAST_TX_SHIFT) begin
                            sda_low_q <= 1'b0;
                            st_q <= SSP_ST_TACK;
                        end else begin
                            sda_low_q <= ~sr_q[6];
                            sr_q <= {sr_q[6:0], 1'b0};
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                end
                SSP_ST_TACK: begin
                    if (scl_rise) begin
                        ack_q <= sda_s_q;
                    end
                    if (scl_fall) begin
                        flag_q <= 1'b1;
                        if (ack_q) begin
                            rw_q <= 1'b0;
                            bf_q <= 1'b0;
                            st_q <= SSP_ST_IDLE;
                        end else begin
                            ctl_q[`SSP_CTL_CKP_BIT] <= 1'b0;
                            st_q <= SSP_ST_HOLD;
                        end
                    end
                end
                default: st_q <= SSP_ST_IDLE;
            endcase
            if (start_det && en) begin
                start_q <= 1'b1;
                stop_q <= 1'b0;
                flag_q <= 1'b1;
                sda_low_q <= 1'b0;
                cnt_q <= 4'h0;
                addr_ph_q <= 1'b1;
                st_q <= slave_on ? SSP_ST_RX : SSP_ST_IDLE;
            end
            if (stop_det && en) begin
                stop_q <= 1'b1;
                start_q <= 1'b0;
                flag_q <= 1'b1;
                sda_low_q <= 1'b0;
                st_q <= SSP_ST_IDLE;
            end
            if (!en) begin
                start_q <= 1'b0;
                stop_q <= 1'b0;
                sda_low_q <= 1'b0;
                st_q <= SSP_ST_IDLE;
            end
        end
    end
endmodule // ssp_dev
`default_nettype wire

// *** src/ssp_host.sv ***
// Bus master end: generates the clock and frames bytes on the bus.
`default_nettype none
`include "ssp_cfg.svh"
module ssp_host import ssp_pkg::*; #(
    parameter int QTR_CYC = `SSP_HOST_QTR_CYC
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire ssp_cmd_t cmd,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_nack,
    output logic cmd_ready,
    output logic [7:0] rx_data,
    output logic rx_ack,
    output logic arb_lost,
    ssp_if.host bus
);
    // ------------------------------------------------------------
    // Divider and synchronisers.
    // ------------------------------------------------------------
    localparam int DW = $clog2(QTR_CYC + 1);
    logic [DW-1:0] div_q;
    logic scl_m_q, scl_s_q, sda_m_q, sda_s_q;
    logic scl_low_q, sda_low_q, is_wr_q, lost_q;
    logic [8:0] tx_q, rx_q;
    logic [3:0] cnt_q;
    logic [1:0] ph_q;
    ssp_host_state_t st_q;
    wire tick = div_q == DW'(QTR_CYC - 1);

    always_ff @(posedge sys_clk) begin
        scl_m_q <= bus.scl;
        scl_s_q <= scl_m_q;
        sda_m_q <= bus.sda;
        sda_s_q <= sda_m_q;
        div_q <= (sys_rst || tick) ? '0 : div_q + DW'(1);
    end

    assign cmd_ready = st_q == SSP_H_IDLE;
    assign bus.host_scl_oe = scl_low_q;
    assign bus.host_sda_oe = sda_low_q;
    assign rx_data = rx_q[8:1];
    assign rx_ack = ~rx_q[0];
    assign arb_lost = lost_q;
    wire clash = is_wr_q && cnt_q < `SSP_BITS_PER_BYTE && !sda_low_q
        && !sda_s_q;

    // ------------------------------------------------------------
    // Framing state machine.
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
            is_wr_q <= 1'b0;
            lost_q <= 1'b0;
            tx_q <= 9'h1FF;
            rx_q <= 9'h000;
            cnt_q <= 4'h0;
            ph_q <= 2'h0;
            st_q <= SSP_H_IDLE;
        end else if (st_q == SSP_H_IDLE) begin
            ph_q <= 2'h0;
            cnt_q <= 4'h0;
            if (cmd_valid) begin
                lost_q <= 1'b0;
                is_wr_q <= cmd == SSP_CMD_WRITE;
                tx_q <= (cmd == SSP_CMD_WRITE) ? {cmd_data, 1'b1}
                    : {8'hFF, cmd_nack};
                case (cmd)
                    SSP_CMD_START: st_q <= SSP_H_START;
                    SSP_CMD_STOP: st_q <= SSP_H_STOP;
                    default: st_q <= SSP_H_BIT;
                endcase
            end
        end else if (tick) begin
            case (st_q)
                SSP_H_START: begin
                    case (ph_q)
                        2'h0: begin
                            sda_low_q <= 1'b0;
                            scl_low_q <= 1'b0;
                            ph_q <= 2'h1;
                        end
                        2'h1: ph_q <= scl_s_q ? 2'h2 : 2'h1;
                        2'h2: begin
                            sda_low_q <= 1'b1;
                            ph_q <= 2'h3;
                        end
                        default: begin
                            scl_low_q <= 1'b1;
                            st_q <= SSP_H_IDLE;
                        end
                    endcase
                end
                SSP_H_BIT: begin
                    case (ph_q)
                        2'h0: begin
                            sda_low_q <= ~tx_q[8];
                            ph_q <= 2'h1;
                        end
                        2'h1: begin
                            scl_low_q <= 1'b0;
                            ph_q <= scl_s_q ? 2'h2 : 2'h1;
                        end
                        2'h2: begin
                            rx_q <= {rx_q[7:0], sda_s_q};
                            ph_q <= 2'h3;
                            if (clash) begin
                                lost_q <= 1'b1;
                                sda_low_q <= 1'b0;
                                st_q <= SSP_H_IDLE;
                            end
                        end
                        default: begin
                            scl_low_q <= 1'b1;
                            tx_q <= {tx_q[7:0], 1'b1};
                            cnt_q <= cnt_q + 4'h1;
                            ph_q <= 2'h0;
                            if (cnt_q == `SSP_BITS_PER_BYTE) begin
                                sda_low_q <= 1'b0;
                                st_q <= SSP_H_IDLE;
                            end
                        end
                    endcase
                end
                SSP_H_STOP: begin
                    case (ph_q)
                        2'h0: begin
                            sda_low_q <= 1'b1;
                            ph_q <= 2'h1;
                        end
                        2'h1: begin
                            scl_low_q <= 1'b0;
                            ph_q <= scl_s_q ? 2'h2 : 2'h1;
                        end
                        default: begin
                            sda_low_q <= 1'b0;
                            st_q <= SSP_H_IDLE;
                        end
                    endcase
                end
                default: st_q <= SSP_H_IDLE;
            endcase
        end
    end
endmodule // ssp_host
`default_nettype wire

// *** verif/ssp_props.sv ***
// Checker of bus timing between the port device and the bus master.
`default_nettype none
module ssp_props (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic dev_scl_oe,
    input wire logic dev_sda_oe,
    input wire logic host_scl_oe,
    input wire logic host_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    // ------------------------------------------------------------
    // Bus properties.
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    a_reset_lines_free: assert property (
        $past(sys_rst) |-> !dev_scl_oe && !dev_sda_oe && !host_scl_oe)
        else $error("lines not free after reset");
    a_tx_stable_high: assert property (
        scl && $past(scl) |-> $stable(dev_sda_oe))
        else $error("device data moved while clock high");
    a_stretch_when_low: assert property (
        $rose(dev_scl_oe) |-> host_scl_oe)
        else $error("device stretch began while clock high");
    a_held_no_shift: assert property (
        dev_scl_oe && $past(dev_scl_oe) && $past(dev_scl_oe, 2)
        |-> $stable(dev_sda_oe))
        else $error("device data moved while clock held");
    a_host_sees_clock: assert property (
        $rose(scl) |-> !host_scl_oe [*2])
        else $error("master pulled clock before seeing it high");
    a_host_quiet_hold: assert property (
        dev_scl_oe && !host_scl_oe |-> $stable(host_sda_oe))
        else $error("master moved data during stretch");
    a_start_frame: assert property (
        scl && $fell(sda) |-> ##[1:80] !scl)
        else $error("start not followed by clock low");
    a_stop_quiet: assert property (
        scl && $rose(sda) |=> (!dev_sda_oe && !dev_scl_oe) [*4])
        else $error("device drove lines after stop");
    c_start: cover property (scl && $fell(sda));
    c_stretch: cover property ($rose(dev_scl_oe));
    c_release: cover property ($fell(dev_scl_oe));
endmodule // ssp_props
`default_nettype wire

// *** verif/ssp_bench.sv ***
// Self-checking bench joining the port device and the bus master.
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
    err_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module ssp_bench import ssp_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic irq;
    logic cmd_valid = 1'b0;
    logic cmd_nack = 1'b0;
    ssp_cmd_t cmd = SSP_CMD_START;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_ready;
    logic rx_ack;
    logic arb_lost;
    logic [7:0] rx_data;
    int err_count = 0;
    int check_count = 0;
    int cyc = 0;
    int sta;
    logic [7:0] rd_v;
    logic [7:0] own;
    logic [7:0] b;
    logic [7:0] txq[$];
    logic [7:0] ra[7] = '{8'h0C, 8'h14, 8'h87, 8'h8C, 8'h93, 8'h94, 8'h55};
    logic [7:0] rv[7] = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
    ssp_if ssp_if_i ();
    ssp_dev ssp_dev_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .bus(ssp_if_i));
    ssp_host #(.QTR_CYC(8)) ssp_host_i (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_data(cmd_data), .cmd_nack(cmd_nack), .cmd_ready(cmd_ready),
        .rx_data(rx_data), .rx_ack(rx_ack), .arb_lost(arb_lost),
        .bus(ssp_if_i));
    ssp_props ssp_props_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .dev_scl_oe(ssp_if_i.dev_scl_oe), .dev_sda_oe(ssp_if_i.dev_sda_oe),
        .host_scl_oe(ssp_if_i.host_scl_oe),
        .host_sda_oe(ssp_if_i.host_sda_oe), .scl(ssp_if_i.scl),
        .sda(ssp_if_i.sda));
    // ------------------------------------------------------------
    // Clock, timeout and bus tasks.
    // ------------------------------------------------------------
    initial forever #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            close_out();
        end
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rchk(input string n, input logic [7:0] a,
        input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rd_v = reg_rdata;
        `CHK(n, e, rd_v)
    endtask
    task automatic hcmd(input ssp_cmd_t c, input logic [7:0] d,
        input logic n);
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd <= c;
        cmd_data <= d;
        cmd_nack <= n;
        @(negedge sys_clk);
        while (cmd_ready !== 1'b1) @(negedge sys_clk);
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
    endtask
    task automatic hrun(input ssp_cmd_t c, input logic [7:0] d);
        hcmd(c, d, 1'b0);
        @(negedge sys_clk);
        while (cmd_ready !== 1'b1) @(negedge sys_clk);
        repeat (4) @(posedge sys_clk);
    endtask
    // ------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------
    initial begin
        void'($urandom(20693));
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        foreach (ra[i]) rchk("reset value", ra[i], rv[i]);
        own = {7'($urandom_range(8, 111)), 1'b0};
        wr(8'h93, own);
        wr(8'h0B, 8'hC0);
        wr(8'h8C, 8'h08);
        wr(8'h14, 8'h26);
        hrun(SSP_CMD_START, 8'h00);
        sta = 8'h08;
        rchk("status", 8'h94, 8'(sta));
        rchk("flag", 8'h0C, 8'h08);
        `CHK("irq", 1'b1, irq)
        wr(8'h8C, 8'h00);
        #1 `CHK("irq masked", 1'b0, irq)
        wr(8'h8C, 8'h08);
        wr(8'h0C, 8'h08);
        #1 `CHK("irq cleared", 1'b0, irq)
        $display("test start done");
        hrun(SSP_CMD_WRITE, own | 8'h01);
        `CHK("address ack", 1'b1, rx_ack)
        `CHK("no clash", 1'b0, arb_lost)
        repeat (20) @(posedge sys_clk);
        #1 `CHK("clock held", 1'b0, ssp_if_i.scl)
        sta = sta | 8'h04;
        rchk("status", 8'h94, 8'(sta));
        rchk("buffer", 8'h13, own | 8'h01);
        rchk("control", 8'h14, 8'h26);
        rchk("flag", 8'h0C, 8'h08);
        wr(8'h0C, 8'h08);
        $display("test address done");
        for (int i = 0; i < 3; i++) begin
            hcmd(SSP_CMD_READ, 8'h00, i == 2);
            repeat (30) @(posedge sys_clk);
            #1 `CHK("master stalled", 1'b0, cmd_ready)
            `CHK("clock held", 1'b0, ssp_if_i.scl)
            b = 8'($urandom);
            txq.push_back(b);
            wr(8'h13, b);
            wr(8'h14, 8'h36);
            @(negedge sys_clk);
            while (cmd_ready !== 1'b1) @(negedge sys_clk);
            repeat (4) @(posedge sys_clk);
            `CHK("tx byte", txq[0], rx_data)
            void'(txq.pop_front());
            `CHK("master ack", 1'(i != 2), rx_ack)
            rchk("flag", 8'h0C, 8'h08);
            wr(8'h0C, 8'h08);
            if (i == 2) sta = 8'h08;
            rchk("status", 8'h94, 8'(sta));
        end
        $display("test transmit done");
        hrun(SSP_CMD_STOP, 8'h00);
        rchk("status", 8'h94, 8'h10);
        rchk("flag", 8'h0C, 8'h08);
        `CHK("irq", 1'b1, irq)
        wr(8'h0C, 8'h08);
        $display("test stop done");
        wr(8'h14, 8'h2B);
        hrun(SSP_CMD_START, 8'h00);
        rchk("status", 8'h94, 8'h08);
        hrun(SSP_CMD_WRITE, own | 8'h01);
        `CHK("idle no ack", 1'b0, rx_ack)
        hrun(SSP_CMD_STOP, 8'h00);
        rchk("status", 8'h94, 8'h10);
        rchk("flag", 8'h0C, 8'h08);
        wr(8'h0C, 8'h08);
        $display("test idle mode done");
        wr(8'h14, 8'h00);
        rchk("status", 8'h94, 8'h00);
        $display("test disable done");
        hrun(SSP_CMD_START, 8'h00);
        hrun(SSP_CMD_WRITE, 8'hFF);
        `CHK("disabled no ack", 1'b0, rx_ack)
        wr(8'h87, 8'hEF);
        #1 `CHK("data low", 1'b0, ssp_if_i.sda)
        wr(8'h87, 8'hFF);
        #1 `CHK("data free", 1'b1, ssp_if_i.sda)
        hrun(SSP_CMD_STOP, 8'h00);
        $display("test pin direction done");
        close_out();
    end
endmodule // ssp_bench
`default_nettype wire
